//--- design/kefcr_pkg.sv
`default_nettype none

package kefcr_pkg;

    // Register map
    localparam logic [7:0] ADDR_KEY_EVENT_QUEUE = 8'h00;
    localparam logic [7:0] ADDR_KEY_SCAN_CONFIG = 8'h01;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Configuration field positions
    localparam int CFG_SLEEP_BIT = 7;
    localparam int CFG_INT_MODE_BIT = 5;
    localparam int CFG_REL_EN_BIT = 3;
    localparam int CFG_WAKE_EN_BIT = 1;
    localparam int CFG_TO_DIS_BIT = 0;
    localparam logic [7:0] CFG_RESET = 8'h0A;
    localparam logic [7:0] CFG_WRITE_MASK = 8'hAB;

    // Queue entry layout: repeat flag, release flag, key number
    localparam int KEY_W = 6;
    localparam int ENTRY_W = 8;
    localparam int ENTRY_REPEAT_BIT = 7;
    localparam int ENTRY_RELEASE_BIT = 6;
    localparam int QUEUE_AW = 4;
    localparam int QUEUE_CW = 5;
    localparam logic [4:0] QUEUE_DEPTH = 5'h10;
    localparam logic [4:0] QUEUE_ONE = 5'h01;
    localparam logic [3:0] PTR_ONE = 4'h1;

    // Read codes
    localparam logic [7:0] CODE_EMPTY = 8'h3F;
    localparam logic [7:0] CODE_OVERFLOW = 8'h7F;
    localparam logic [5:0] KEY_REPEAT_CODE = 6'h3E;
    localparam logic [4:0] KEY_HIGH_PAIR = 5'h1F;

    typedef enum logic {
        LINK_IDLE,
        LINK_WAIT
    } kefcr_link_state_t;

endpackage

`default_nettype wire

//--- design/kefcr_event_fifo.sv
`timescale 1ns/100ps
`default_nettype none

module kefcr_event_fifo (
    input wire logic clock, // Core clock
    input wire logic rstn, // Synchronous reset, active low
    input wire logic pushValid, // Offer an entry
    input wire logic [kefcr_pkg::ENTRY_W-1:0] pushData, // Entry to store
    input wire logic popValid, // Remove head entry
    output logic [kefcr_pkg::ENTRY_W-1:0] headData, // Oldest entry
    output logic [kefcr_pkg::QUEUE_CW-1:0] count, // Entries held
    output logic full, // No room
    output logic empty // Nothing held
);
    logic [kefcr_pkg::ENTRY_W-1:0] mem [16];
    logic [kefcr_pkg::QUEUE_AW-1:0] wrPtr;
    logic [kefcr_pkg::QUEUE_AW-1:0] rdPtr;
    logic doPush;
    logic doPop;
    logic [kefcr_pkg::QUEUE_CW-1:0] next_count;

    assign empty = (count == '0);
    assign full = (count == kefcr_pkg::QUEUE_DEPTH);
    // A push into a full queue is fine when the head leaves the same cycle
    assign doPush = pushValid & (~full | popValid);
    assign doPop = popValid & ~empty;
    assign headData = mem[rdPtr];
    assign next_count = doPush & ~doPop ? count + kefcr_pkg::QUEUE_ONE :
                        doPop & ~doPush ? count - kefcr_pkg::QUEUE_ONE : count;

    always_ff @(posedge clock) begin
        if (doPush) begin
            mem[wrPtr] <= pushData;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            wrPtr <= doPush ? wrPtr + kefcr_pkg::PTR_ONE : wrPtr;
            rdPtr <= doPop ? rdPtr + kefcr_pkg::PTR_ONE : rdPtr;
            count <= next_count;
        end
    end

endmodule

`default_nettype wire

//--- design/kefcr_regs.sv
// Functional notes
// - Event read gives key in 5:0, release in 6, more-data in 7.
// - Empty reads 0x3F; overflow reads 0x7F; host keeps reading after overflow.
// - Repeat entry reads key 111110, bit 7 clear, bit 6 means more.
// - Keys 62/63 read with bit 7 set; host reads again for more.
// - Constant-current PWM on keeps keys active and freezes the sleep bit.
// - PWM off: sleep bit 0 shuts chip down, 1 operates; resets to 0.
// - PWM off: host write, autosleep and autowake may change sleep bit.
// - Sleep bit reads back the current sleep or operating state.
// - Interrupt mode 0 clears when queue empty, 1 after any event queue read; default 0.
// - Release enable bit gates queuing of releases; resets to 1.
// - Autowake bit lets a keypress wake the device; resets to 1.
`timescale 1ns/100ps
`default_nettype none

module kefcr_regs (
    input wire logic clock, // Core clock, 50 MHz
    input wire logic rstn, // Synchronous reset, active low
    input wire logic linkClock, // Serial front end clock
    input wire logic accReq, // Access request pulse, link domain
    input wire logic accWrite, // 1 write, 0 read
    input wire logic [7:0] accAddr, // Register address
    input wire logic [7:0] accWrData, // Write data
    output logic accBusy, // Access in flight, link domain
    output logic accDone, // Access finished pulse, link domain
    output logic [7:0] accRdData, // Read data, valid with accDone
    input wire logic evtValid, // Debounced key event pulse
    input wire logic [kefcr_pkg::KEY_W-1:0] evtKey, // Key number
    input wire logic evtRelease, // Event is a release
    input wire logic evtRepeat, // Event is an autorepeat
    input wire logic intRequest, // Interrupt rate logic asks to assert
    input wire logic pwmEnable, // Constant-current PWM enabled
    input wire logic autoSleepReq, // Sleep timeout elapsed pulse
    input wire logic keypressWake, // Keypress seen while asleep pulse
    output logic keyInterruptOutN, // Key interrupt, active low
    output logic keyScanActive, // Key switches monitored
    output logic chipShutdown, // Whole chip in sleep
    output logic busTimeoutEn // Serial bus timeout active
);
    // Link domain
    kefcr_pkg::kefcr_link_state_t linkState;
    logic linkRstnMeta;
    logic linkRstn;
    logic reqToggle;
    logic reqWrite;
    logic [7:0] reqAddr;
    logic [7:0] reqData;
    logic ackMeta;
    logic ackSync;
    logic ackSeen;
    logic linkStart;
    logic linkFinish;

    // Core domain
    logic reqMeta;
    logic reqSync;
    logic reqSeen;
    logic ackToggle;
    logic [7:0] coreRdData;
    logic coreReq;
    logic queueRead;
    logic cfgRead;
    logic cfgWrite;
    logic [7:0] readValue;

    logic [7:0] cfg;
    logic sleepBit;
    logic next_sleepBit;
    logic overflowFlag;
    logic next_overflowFlag;
    logic [7:0] next_cfg;
    logic next_accBusy;
    logic next_keyInterruptOutN;
    logic next_keyScanActive;
    logic next_chipShutdown;
    logic next_busTimeoutEn;
    logic intClear;

    logic pushValid;
    logic pushBlocked;
    logic popValid;
    logic [kefcr_pkg::ENTRY_W-1:0] pushData;
    logic [kefcr_pkg::ENTRY_W-1:0] headData;
    logic [kefcr_pkg::QUEUE_CW-1:0] count;
    logic full;
    logic empty;
    logic moreData;
    logic headRepeat;
    logic headRelease;
    logic headHighKey;
    logic [7:0] entryCode;
    logic [7:0] queueCode;
    logic [7:0] cfgReadValue;

    // Link side: the clock may stop between frames, so each access is a
    // self-contained toggle handshake that ends on this clock
    assign linkStart = accReq & (linkState == kefcr_pkg::LINK_IDLE);
    assign linkFinish = (linkState == kefcr_pkg::LINK_WAIT) & (ackSync != ackSeen);
    assign next_accBusy = linkStart | (accBusy & ~linkFinish);

    always_ff @(posedge linkClock) begin
        linkRstnMeta <= rstn;
        linkRstn <= linkRstnMeta;
    end

    always_ff @(posedge linkClock) begin
        ackMeta <= ackToggle;
        ackSync <= ackMeta;
    end

    always_ff @(posedge linkClock) begin
        if (!linkRstn) begin
            linkState <= kefcr_pkg::LINK_IDLE;
            reqToggle <= 1'b0;
            ackSeen <= 1'b0;
        end else begin
            unique case (linkState)
                kefcr_pkg::LINK_IDLE: begin
                    if (linkStart) begin
                        reqToggle <= ~reqToggle;
                        linkState <= kefcr_pkg::LINK_WAIT;
                    end
                end
                kefcr_pkg::LINK_WAIT: begin
                    if (linkFinish) begin
                        ackSeen <= ackSync;
                        linkState <= kefcr_pkg::LINK_IDLE;
                    end
                end
            endcase
        end
    end

    // Busy and done come straight from flops so the front end sees clean levels
    always_ff @(posedge linkClock) begin
        if (!linkRstn) begin
            accBusy <= 1'b0;
            accDone <= 1'b0;
        end else begin
            accBusy <= next_accBusy;
            accDone <= linkFinish;
        end
    end

    // Request fields stay put until the acknowledge returns
    always_ff @(posedge linkClock) begin
        if (!linkRstn) begin
            reqWrite <= 1'b0;
            reqAddr <= 8'h00;
            reqData <= 8'h00;
            accRdData <= 8'h00;
        end else begin
            if (linkStart) begin
                reqWrite <= accWrite;
                reqAddr <= accAddr;
                reqData <= accWrData;
            end
            if (linkFinish) begin
                accRdData <= coreRdData;
            end
        end
    end

    // Core side of the handshake
    always_ff @(posedge clock) begin
        reqMeta <= reqToggle;
        reqSync <= reqMeta;
    end

    // Decode only while a request is pending; its fields are stable by then
    assign coreReq = reqSync != reqSeen;
    assign queueRead = coreReq & ~reqWrite & (reqAddr == kefcr_pkg::ADDR_KEY_EVENT_QUEUE);
    assign cfgRead = coreReq & ~reqWrite & (reqAddr == kefcr_pkg::ADDR_KEY_SCAN_CONFIG);
    assign cfgWrite = coreReq & reqWrite & (reqAddr == kefcr_pkg::ADDR_KEY_SCAN_CONFIG);

    always_ff @(posedge clock) begin
        if (!rstn) begin
            reqSeen <= 1'b0;
            ackToggle <= 1'b0;
            coreRdData <= 8'h00;
        end else begin
            reqSeen <= reqSync;
            if (coreReq) begin
                ackToggle <= ~ackToggle;
                coreRdData <= readValue;
            end
        end
    end

    // Event queue
    assign pushValid = evtValid & (evtRepeat | ~evtRelease | cfg[kefcr_pkg::CFG_REL_EN_BIT]);
    assign pushData = {evtRepeat, evtRelease, evtKey};
    assign pushBlocked = pushValid & full & ~popValid;
    // Overflow code is returned instead of the head, so it never pops
    assign popValid = queueRead & ~overflowFlag & ~empty;

    // Sixteen entries; the overflow flag stands for whatever does not fit
    kefcr_event_fifo u_queue (
        .clock(clock),
        .rstn(rstn),
        .pushValid(pushValid),
        .pushData(pushData),
        .popValid(popValid),
        .headData(headData),
        .count(count),
        .full(full),
        .empty(empty)
    );

    // The entry being read still counts, hence more data means above one
    assign moreData = count > kefcr_pkg::QUEUE_ONE;
    assign headRepeat = headData[kefcr_pkg::ENTRY_REPEAT_BIT];
    assign headRelease = headData[kefcr_pkg::ENTRY_RELEASE_BIT];
    assign headHighKey = ~headRepeat & (headData[5:1] == kefcr_pkg::KEY_HIGH_PAIR);
    assign entryCode = headRepeat ? {1'b0, moreData, kefcr_pkg::KEY_REPEAT_CODE} :
                       headHighKey ? {1'b1, headRelease, headData[5:0]} :
                       {moreData, headRelease, headData[5:0]};
    assign queueCode = overflowFlag ? kefcr_pkg::CODE_OVERFLOW :
                       empty ? kefcr_pkg::CODE_EMPTY : entryCode;

    // Sleep bit reads as state; PWM on means keys are awake
    assign cfgReadValue = (cfg & kefcr_pkg::CFG_WRITE_MASK & 8'h7F) |
                          {sleepBit | pwmEnable, 7'h00};
    // Unmapped addresses read a fixed value and ignore writes
    assign readValue = queueRead ? queueCode :
                       cfgRead ? cfgReadValue : kefcr_pkg::UNMAPPED_READ;

    // A new overflow in the read cycle keeps the flag, so no lost event
    // goes unreported; the code is shown once, ahead of the queued entries
    assign next_overflowFlag = pushBlocked | (overflowFlag & ~queueRead);

    always_ff @(posedge clock) begin
        if (!rstn) begin
            overflowFlag <= 1'b0;
        end else begin
            overflowFlag <= next_overflowFlag;
        end
    end

    // Configuration; the sleep bit lives apart so autosleep and autowake can
    // move it, and reserved bits never reach the stored copy
    assign next_cfg = cfgWrite ? (reqData & kefcr_pkg::CFG_WRITE_MASK & 8'h7F) : cfg;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            cfg <= kefcr_pkg::CFG_RESET;
        end else begin
            cfg <= next_cfg;
        end
    end

    // Host write beats autowake, autowake beats autosleep
    assign next_sleepBit = pwmEnable ? sleepBit :
                           cfgWrite ? reqData[kefcr_pkg::CFG_SLEEP_BIT] :
                           keypressWake & cfg[kefcr_pkg::CFG_WAKE_EN_BIT] ? 1'b1 :
                           autoSleepReq ? 1'b0 : sleepBit;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            sleepBit <= 1'b0;
        end else begin
            sleepBit <= next_sleepBit;
        end
    end

    // Interrupt: set wins over clear
    assign intClear = cfg[kefcr_pkg::CFG_INT_MODE_BIT] ? queueRead :
                      (empty & ~overflowFlag & ~pushValid);

    // Held low until cleared; a request in the clearing cycle keeps it low
    assign next_keyInterruptOutN = ~(intRequest | (~keyInterruptOutN & ~intClear));

    always_ff @(posedge clock) begin
        if (!rstn) begin
            keyInterruptOutN <= 1'b1;
        end else begin
            keyInterruptOutN <= next_keyInterruptOutN;
        end
    end

    // Status outputs lag their causes by one cycle, traded for glitch-free pins
    assign next_keyScanActive = pwmEnable | sleepBit;
    assign next_chipShutdown = ~pwmEnable & ~sleepBit;
    assign next_busTimeoutEn = ~cfg[kefcr_pkg::CFG_TO_DIS_BIT];

    always_ff @(posedge clock) begin
        if (!rstn) begin
            keyScanActive <= 1'b0;
            chipShutdown <= 1'b1;
            busTimeoutEn <= 1'b1;
        end else begin
            keyScanActive <= next_keyScanActive;
            chipShutdown <= next_chipShutdown;
            busTimeoutEn <= next_busTimeoutEn;
        end
    end

endmodule

`default_nettype wire

//--- dv/kefcr_regs_asserts.sv
`timescale 1ns/100ps
`default_nettype none

module kefcr_regs_asserts (
    input wire logic clock, // Core clock
    input wire logic rstn, // Reset, active low
    input wire logic linkClock, // Link clock
    input wire logic accReq, // Access request
    input wire logic accBusy, // Access in flight
    input wire logic accDone, // Access finished
    input wire logic [7:0] accRdData, // Read data
    input wire logic intRequest, // Interrupt ask
    input wire logic pwmEnable, // PWM enabled
    input wire logic keyInterruptOutN, // Interrupt, active low
    input wire logic keyScanActive, // Keys watched
    input wire logic chipShutdown // Chip asleep
);
    sequence take_s;
        accReq && !accBusy;
    endsequence
    sequence finish_s;
        accDone && !accBusy;
    endsequence
    accept_busy_a: assert property (@(posedge linkClock) disable iff (!rstn) take_s |=> accBusy)
        else $error("busy missing after accept");
    access_bound_a: assert property (@(posedge linkClock) disable iff (!rstn) take_s |-> ##[2:8] finish_s)
        else $error("access not finished in time");
    done_pulse_a: assert property (@(posedge linkClock) disable iff (!rstn) accDone |=> !accDone)
        else $error("done longer than one cycle");
    read_hold_a: assert property (@(posedge linkClock) disable iff (!rstn) !accDone |-> $stable(accRdData))
        else $error("read data moved without done");
    scan_pwm_a: assert property (@(posedge clock) disable iff (!rstn) $past(rstn) && $past(pwmEnable) |-> keyScanActive)
        else $error("keys idle while pwm on");
    shut_inverse_a: assert property (@(posedge clock) disable iff (!rstn) chipShutdown != keyScanActive)
        else $error("shutdown and scan agree");
    int_assert_a: assert property (@(posedge clock) disable iff (!rstn) intRequest |=> !keyInterruptOutN)
        else $error("interrupt not asserted");
    int_cause_a: assert property (@(posedge clock) disable iff (!rstn) $fell(keyInterruptOutN) |-> $past(intRequest))
        else $error("interrupt without request");
endmodule

bind kefcr_regs kefcr_regs_asserts i_kefcr_regs_asserts (.clock(clock), .rstn(rstn),
    .linkClock(linkClock), .accReq(accReq), .accBusy(accBusy), .accDone(accDone),
    .accRdData(accRdData), .intRequest(intRequest), .pwmEnable(pwmEnable),
    .keyInterruptOutN(keyInterruptOutN), .keyScanActive(keyScanActive),
    .chipShutdown(chipShutdown));

`default_nettype wire

//--- dv/kefcr_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module kefcr_host_model (
    input wire logic linkClock, // Link clock
    input wire logic accDone, // Access finished
    input wire logic [7:0] accRdData, // Read data
    output logic hostRun, // Keeps link clock running
    output logic accReq, // Access request pulse
    output logic accWrite, // 1 write, 0 read
    output logic [7:0] accAddr, // Register address
    output logic [7:0] accWrData // Write data
);
    initial begin
        hostRun = 1'b0;
        accReq = 1'b0;
        accWrite = 1'b0;
        accAddr = 8'h00;
        accWrData = 8'h00;
    end
    // Link clock runs only around an access or in reset, so no free edges hide bugs
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
            output logic [7:0] rdData);
        int n;
        // Step off the last edge of any access just ended before restarting
        #1;
        hostRun = 1'b1;
        repeat (3) @(posedge linkClock);
        accReq <= 1'b1;
        accWrite <= wr;
        accAddr <= a;
        accWrData <= d;
        @(posedge linkClock);
        accReq <= 1'b0;
        n = 0;
        while (accDone !== 1'b1 && n < 20) begin
            @(negedge linkClock);
            n++;
        end
        if (accDone !== 1'b1) begin
            tb.err_count++;
            $display("[FAIL] access done expected 1 seen %0h", accDone);
        end
        rdData = accRdData;
        @(posedge linkClock);
        accAddr <= ~a;
        accWrData <= ~d;
        hostRun = 1'b0;
    endtask
endmodule

`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end

module tb;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic linkClock = 1'b0;
    logic hostRun, accReq, accWrite, accBusy, accDone;
    logic [7:0] accAddr, accWrData, accRdData;
    logic evtValid = 1'b0, evtRelease = 1'b0, evtRepeat = 1'b0, pwmEnable = 1'b0;
    logic intRequest = 1'b0, autoSleepReq = 1'b0, keypressWake = 1'b0;
    logic [5:0] evtKey = 6'h00;
    logic keyInterruptOutN, keyScanActive, chipShutdown, busTimeoutEn;
    wire linkRun;
    int err_count = 0;
    int checks_done = 0;
    assign linkRun = hostRun | ~rstn;
    always #10 clock = ~clock;
    always #62.5 linkClock = linkRun ? ~linkClock : 1'b0;
    kefcr_regs i_kefcr_regs (.clock(clock), .rstn(rstn), .linkClock(linkClock),
        .accReq(accReq), .accWrite(accWrite), .accAddr(accAddr), .accWrData(accWrData),
        .accBusy(accBusy), .accDone(accDone), .accRdData(accRdData), .evtValid(evtValid),
        .evtKey(evtKey), .evtRelease(evtRelease), .evtRepeat(evtRepeat),
        .intRequest(intRequest), .pwmEnable(pwmEnable), .autoSleepReq(autoSleepReq),
        .keypressWake(keypressWake), .keyInterruptOutN(keyInterruptOutN),
        .keyScanActive(keyScanActive), .chipShutdown(chipShutdown),
        .busTimeoutEn(busTimeoutEn));
    kefcr_host_model i_kefcr_host_model (.linkClock(linkClock), .accDone(accDone),
        .accRdData(accRdData), .hostRun(hostRun), .accReq(accReq), .accWrite(accWrite),
        .accAddr(accAddr), .accWrData(accWrData));
    task automatic conclude();
        $display("Checks %0d, errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        i_kefcr_host_model.access(1'b0, a, 8'h00, v);
        `CHK("read data", e, v)
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        i_kefcr_host_model.access(1'b1, a, d, v);
        repeat (3) @(negedge clock);
    endtask
    task automatic evt(input logic [5:0] k, input logic rel, input logic rep);
        @(posedge clock);
        evtValid <= 1'b1;
        evtKey <= k;
        evtRelease <= rel;
        evtRepeat <= rep;
        @(posedge clock);
        evtValid <= 1'b0;
    endtask
    // Bits are interrupt, autosleep, wake
    task automatic pulse(input logic [2:0] p);
        @(posedge clock);
        {intRequest, autoSleepReq, keypressWake} <= p;
        @(posedge clock);
        {intRequest, autoSleepReq, keypressWake} <= 3'h0;
        repeat (3) @(negedge clock);
    endtask
    task automatic t_reset();
        `CHK("interrupt idle", 1'b1, keyInterruptOutN)
        `CHK("shutdown", 1'b1, chipShutdown)
        `CHK("timeout on", 1'b1, busTimeoutEn)
        rd(8'h01, 8'h0A);
        rd(8'h00, 8'h3F);
        rd(8'h05, 8'h00);
    endtask
    task automatic t_config();
        wr(8'h01, 8'hAB);
        rd(8'h01, 8'hAB);
        `CHK("timeout off", 1'b0, busTimeoutEn)
        `CHK("keys active", 1'b1, keyScanActive)
        wr(8'h00, 8'h55);
        rd(8'h00, 8'h3F);
    endtask
    task automatic t_events();
        wr(8'h01, 8'h8A);
        evt(6'h05, 1'b0, 1'b0);
        evt(6'h09, 1'b1, 1'b0);
        evt(6'h03, 1'b0, 1'b1);
        evt(6'h3F, 1'b0, 1'b0);
        evt(6'h3E, 1'b1, 1'b0);
        evt(6'h03, 1'b0, 1'b1);
        rd(8'h00, 8'h85);
        rd(8'h00, 8'hC9);
        rd(8'h00, 8'h7E);
        rd(8'h00, 8'hBF);
        rd(8'h00, 8'hFE);
        rd(8'h00, 8'h3E);
        rd(8'h00, 8'h3F);
    endtask
    task automatic t_release();
        wr(8'h01, 8'h82);
        evt(6'h04, 1'b1, 1'b0);
        evt(6'h07, 1'b0, 1'b0);
        rd(8'h00, 8'h07);
        rd(8'h00, 8'h3F);
    endtask
    task automatic t_overflow();
        for (int i = 0; i < 17; i++) begin
            evt(6'(i), 1'b0, 1'b0);
        end
        rd(8'h00, 8'h7F);
        for (int i = 0; i < 16; i++) begin
            rd(8'h00, {i < 15, 1'b0, 6'(i)});
        end
        rd(8'h00, 8'h3F);
    endtask
    task automatic t_interrupt();
        wr(8'h01, 8'h8A);
        evt(6'h02, 1'b0, 1'b0);
        pulse(3'h4);
        `CHK("interrupt set", 1'b0, keyInterruptOutN)
        rd(8'h00, 8'h02);
        repeat (3) @(negedge clock);
        `CHK("cleared on empty", 1'b1, keyInterruptOutN)
        wr(8'h01, 8'hAA);
        evt(6'h02, 1'b0, 1'b0);
        evt(6'h03, 1'b0, 1'b0);
        pulse(3'h4);
        rd(8'h00, 8'h82);
        repeat (3) @(negedge clock);
        `CHK("cleared on read", 1'b1, keyInterruptOutN)
        rd(8'h00, 8'h03);
    endtask
    task automatic t_sleep();
        wr(8'h01, 8'h0A);
        `CHK("asleep", 1'b1, chipShutdown)
        pulse(3'h1);
        `CHK("woken", 1'b1, keyScanActive)
        rd(8'h01, 8'h8A);
        pulse(3'h2);
        `CHK("autosleep", 1'b1, chipShutdown)
        wr(8'h01, 8'h08);
        pulse(3'h1);
        `CHK("no wake", 1'b0, keyScanActive)
        @(posedge clock);
        pwmEnable <= 1'b1;
        wr(8'h01, 8'h88);
        `CHK("pwm keys on", 1'b1, keyScanActive)
        rd(8'h01, 8'h88);
        @(posedge clock);
        pwmEnable <= 1'b0;
        repeat (3) @(negedge clock);
        `CHK("sleep frozen", 1'b0, keyScanActive)
    endtask
    initial begin
        repeat (4) @(posedge clock);
        repeat (3) @(posedge linkClock);
        @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(negedge clock);
        t_reset();
        t_config();
        t_events();
        t_release();
        t_overflow();
        t_interrupt();
        t_sleep();
        conclude();
    end
    initial begin
        #1000000;
        err_count++;
        conclude();
    end
endmodule

`default_nettype wire
